// ### mpg_pkg.sv
/*
 * Constants, register layouts and carrier types of the motor PWM block.
 * Assumes a 100 MHz core clock and a plain one-cycle register port.
 */
//
// Contract
// - Six PWM channels, independent or three pairs, each pair with dead time (applied in complementary mode only).
// - Shared prescaler divides by 1, 2, 4 up to 256, nine ratios.
// - Period counter is 17 bits wide; period and duty compare values are 16 bits.
// - Fourteen match flags, each raises interrupt only when its enable is set.
// - One-shot gives one cycle, auto-reload repeats; one-shot edge-aligned only.
// - Period and compare writes go to buffers, loaded at period end.
// - Complementary pair odd is inverse of even; synchronous pair in phase.
// - Internal signals positive logic; per-port polarity sets pin level.
// - Converter trigger on down match, center, up match or period match.
// - Comparator event forces outputs low for at most one period.
// - Two brake detectors, four sources; one latches, one resumes alone.
// - Engine runs only while the module clock gate is enabled.
// - Edge-aligned counts down from period; compare match drives output high.
// - Edge-aligned at zero: output low, buffers load, period flag set.
// - Edge frequency is clock over prescale over period plus one.
// - Edge: high if compare above period, low if zero, else compare units.
// - Center: down from period plus one, high on match, up after zero.
// - Center: buffers load when up count reaches period at period end.
// - Center period 2*(period+1), high time 2*compare units, same limits.
// - Center mode raises period, up match, center and down match flags.
// - Mode 00 independent, 01 complementary, 10 synchronous pairs.
// - Count mode bit 0 one-shot, 1 auto-reload.
// - Hardware sets interrupt flags; only software clears them.
// - Complementary pairs delay turn-on by an 8-bit dead-time counter.
package mpg_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CTL = 8'h00;
   localparam logic [7:0] OFS_PSEL = 8'h04;
   localparam logic [7:0] OFS_PERIOD = 8'h08;
   localparam logic [7:0] OFS_CMP0 = 8'h0C;
   localparam logic [7:0] OFS_CMP5 = 8'h20;
   localparam logic [7:0] OFS_INTEN = 8'h24;
   localparam logic [7:0] OFS_FLAGS = 8'h28;
   localparam logic [7:0] OFS_DEAD = 8'h2C;
   localparam logic [7:0] OFS_BRK = 8'h30;
   localparam logic [7:0] OFS_BRKREL = 8'h34;
   localparam logic [7:0] OFS_STATUS = 8'h38;

   // -----------------------------------------------------------------
   // Fields and timing
   // -----------------------------------------------------------------
   localparam int NCH = 6;
   localparam int NPAIR = 3;
   localparam logic [1:0] MODE_INDEP = 2'h0;
   localparam logic [1:0] MODE_COMPL = 2'h1;
   localparam logic [1:0] MODE_SYNC = 2'h2;
   localparam logic [3:0] PSEL_MAX = 4'h8;
   localparam logic [11:0] RESUME_CNT = 12'hFFF;
   localparam int ADC_DN = 0;
   localparam int ADC_CEN = 1;
   localparam int ADC_UP = 2;
   localparam int ADC_PER = 3;

   typedef struct packed {
      logic [5:0] pol;
      logic [3:0] adc_sel;
      logic force_en;
      logic run;
      logic center;
      logic count_reload_select;
      logic [1:0] mode;
   } mpg_ctl_t;

   typedef struct packed {
      logic [5:0] level;
      logic [3:0] en1;
      logic [3:0] en0;
   } mpg_brk_t;

   typedef struct packed {
      logic [1:0] brk;
      logic [5:0] down_compare_flag;
      logic [5:0] up_compare_flag;
      logic center_point_flag;
      logic period_match_flag;
   } mpg_flags_t;

   localparam int CTL_W = $bits(mpg_ctl_t);
   localparam int BRK_W = $bits(mpg_brk_t);
   localparam int FLG_W = $bits(mpg_flags_t);

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } mpg_bus_t;

   typedef struct packed {
      logic fault_pin;
      logic converter_unit;
      logic [1:0] analog_comparator;
   } mpg_fault_t;

endpackage : mpg_pkg

// ### mpg_top.sv
/*
 * Six-channel motor PWM generator with register port, brakes and
 * converter trigger. Assumes all inputs synchronous to core_clk.
 */
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module mpg_top (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire mpg_pkg::mpg_bus_t bus,
   output logic [31:0] rdata,
   input wire logic module_clock_gate,
   input wire mpg_pkg::mpg_fault_t fault,
   input wire logic force_low_evt,
   output logic [5:0] channel_generator_output,
   output logic irq,
   output logic adc_trig
);
   import mpg_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      mpg_ctl_t ctl;
      mpg_brk_t brk;
      logic [3:0] prescale_select;
      logic [15:0] per_buf;
      logic [15:0] per_act;
      logic [NCH-1:0][15:0] duty_compare_value;
      logic [NCH-1:0][15:0] cmp_act;
      mpg_flags_t inten;
      mpg_flags_t flags;
      logic [NPAIR-1:0][7:0] dead;
      logic [7:0] pcnt;
      logic [16:0] cnt;
      logic up;
      logic active;
      logic force_lo;
      logic latching_brake_detector;
      logic resuming_brake_detector;
      logic [11:0] rcnt;
      logic [NPAIR-1:0] dly;
      logic [NPAIR-1:0][7:0] dcnt;
      logic [NPAIR-1:0] dprev;
      logic [5:0] pin;
      logic [31:0] rdata;
      logic irq;
      logic adc;
   } mpg_state_t;

   mpg_state_t s_reg;
   mpg_state_t s_next;
   mpg_flags_t set_f;
   mpg_flags_t clr_f;
   logic [NCH-1:0] raw;
   logic [NCH-1:0] ch;
   logic [3:0] src;
   logic [3:0] psel;
   logic [7:0] lim;
   logic tick;
   logic pend;
   logic rel;
   logic hit0;
   logic hit1;
   logic ev_dn;
   logic ev_up;
   logic [2:0] cidx;
   logic e;
   logic o;

   assign rdata = s_reg.rdata;
   assign channel_generator_output = s_reg.pin;
   assign irq = s_reg.irq;
   assign adc_trig = s_reg.adc;

   always_comb begin
      s_next = s_reg;
      s_next.rdata = '0;
      set_f = '0;
      clr_f = '0;
      rel = 1'b0;
      tick = 1'b0;
      pend = 1'b0;
      ch = '0;
      e = 1'b0;
      o = 1'b0;
      raw = '0;
      src = '0;
      psel = '0;
      lim = '0;
      hit0 = 1'b0;
      hit1 = 1'b0;
      ev_dn = 1'b0;
      ev_up = 1'b0;
      cidx = 3'((bus.addr - OFS_CMP0) >> 2);

      // -------------------------------------------------------------
      // Register writes
      // -------------------------------------------------------------
      if (bus.wr) begin
         if (bus.addr >= OFS_CMP0 && bus.addr <= OFS_CMP5) begin
            s_next.duty_compare_value[cidx] = bus.wdata[15:0];
         end
         case (bus.addr)
            OFS_CTL: s_next.ctl = mpg_ctl_t'(bus.wdata[CTL_W-1:0]);
            OFS_PSEL: s_next.prescale_select = bus.wdata[3:0];
            OFS_PERIOD: s_next.per_buf = bus.wdata[15:0];
            OFS_INTEN: s_next.inten = mpg_flags_t'(bus.wdata[FLG_W-1:0]);
            OFS_FLAGS: clr_f = mpg_flags_t'(bus.wdata[FLG_W-1:0]);
            OFS_DEAD: s_next.dead = bus.wdata[23:0];
            OFS_BRK: s_next.brk = mpg_brk_t'(bus.wdata[BRK_W-1:0]);
            OFS_BRKREL: rel = bus.wdata[0];
            default: ;
         endcase
      end

      // -------------------------------------------------------------
      // Register reads, data in the following cycle
      // -------------------------------------------------------------
      if (bus.rd) begin
         if (bus.addr >= OFS_CMP0 && bus.addr <= OFS_CMP5) begin
            s_next.rdata = 32'(s_reg.duty_compare_value[cidx]);
         end
         case (bus.addr)
            OFS_CTL: s_next.rdata = 32'(s_reg.ctl);
            OFS_PSEL: s_next.rdata = 32'(s_reg.prescale_select);
            OFS_PERIOD: s_next.rdata = 32'(s_reg.per_buf);
            OFS_INTEN: s_next.rdata = 32'(s_reg.inten);
            OFS_FLAGS: s_next.rdata = 32'(s_reg.flags);
            OFS_DEAD: s_next.rdata = 32'(s_reg.dead);
            OFS_BRK: s_next.rdata = 32'(s_reg.brk);
            // Status word is exactly 32 bits, pins at 25:20
            OFS_STATUS: s_next.rdata = {6'h00, s_reg.pin,
               s_reg.resuming_brake_detector,
               s_reg.latching_brake_detector,
               s_reg.active,
               s_reg.up,
               s_reg.cnt[15:0]};
            default: ;
         endcase
      end

      // -------------------------------------------------------------
      // Prescaler and counter
      // -------------------------------------------------------------
      psel = (s_reg.prescale_select > PSEL_MAX) ? PSEL_MAX
                                                : s_reg.prescale_select;
      lim = 8'((9'h001 << psel) - 9'h001);
      if (module_clock_gate && s_reg.active) begin
         // One tick per prescaled unit of width
         tick = (s_reg.pcnt == lim);
         s_next.pcnt = tick ? 8'h00 : s_reg.pcnt + 8'h01;
      end
      if (tick) begin
         for (int i = 0; i < NCH; i++) begin
            ev_dn = !s_reg.up && s_reg.cnt == 17'(s_reg.cmp_act[i]);
            ev_up = s_reg.up && s_reg.cnt == 17'(s_reg.cmp_act[i]);
            if (ev_dn) begin
               set_f.down_compare_flag[i] = 1'b1;
            end
            if (ev_up) begin
               set_f.up_compare_flag[i] = 1'b1;
            end
         end
         if (!s_reg.ctl.center) begin
            if (s_reg.cnt == 17'h00000) begin
               pend = 1'b1;
            end else begin
               s_next.cnt = s_reg.cnt - 17'h00001;
            end
         end else if (!s_reg.up) begin
            if (s_reg.cnt == 17'h00001) begin
               s_next.cnt = 17'h00000;
               s_next.up = 1'b1;
               set_f.center_point_flag = 1'b1;
            end else begin
               s_next.cnt = s_reg.cnt - 17'h00001;
            end
         end else if (s_reg.cnt == 17'(s_reg.per_act)) begin
            pend = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt + 17'h00001;
         end
      end

      // -------------------------------------------------------------
      // Period end and start
      // -------------------------------------------------------------
      if (pend) begin
         set_f.period_match_flag = 1'b1;
         s_next.per_act = s_reg.per_buf;
         s_next.cmp_act = s_reg.duty_compare_value;
         s_next.force_lo = 1'b0;
         s_next.up = 1'b0;
         // Center counting always reloads, one-shot is edge only
         if (!s_reg.ctl.center && !s_reg.ctl.count_reload_select) begin
            s_next.active = 1'b0;
            s_next.ctl.run = 1'b0;
         end else if (s_reg.ctl.center) begin
            s_next.cnt = 17'(s_reg.per_buf) + 17'h00001;
         end else begin
            s_next.cnt = 17'(s_reg.per_buf);
         end
      end
      if (s_reg.ctl.run && !s_reg.active) begin
         s_next.active = 1'b1;
         s_next.pcnt = 8'h00;
         s_next.up = 1'b0;
         s_next.per_act = s_reg.per_buf;
         s_next.cmp_act = s_reg.duty_compare_value;
         s_next.cnt = s_reg.ctl.center ? 17'(s_reg.per_buf) + 17'h00001
                                        : 17'(s_reg.per_buf);
      end
      if (!s_reg.ctl.run && s_reg.active) begin
         s_next.active = 1'b0;
      end

      // -------------------------------------------------------------
      // Duty comparison
      // -------------------------------------------------------------
      for (int i = 0; i < NCH; i++) begin
         if (!s_reg.active || s_reg.cmp_act[i] == 16'h0000) begin
            raw[i] = 1'b0;
         end else if (s_reg.cmp_act[i] > s_reg.per_act) begin
            raw[i] = 1'b1;
         end else if (s_reg.up) begin
            raw[i] = s_reg.cnt < 17'(s_reg.cmp_act[i]);
         end else begin
            raw[i] = s_reg.cnt <= 17'(s_reg.cmp_act[i]) &&
                     s_reg.cnt != 17'h00000;
         end
      end

      // -------------------------------------------------------------
      // Pairing and dead time
      // -------------------------------------------------------------
      for (int k = 0; k < NPAIR; k++) begin
         e = raw[2*k];
         o = raw[2*k+1];
         s_next.dprev[k] = e;
         if (s_reg.ctl.mode == MODE_COMPL) begin
            o = s_reg.active & ~e;
            // Change cycle itself is blanked, then dead more cycles,
            // so a turn-on is delayed and never shows as a glitch
            if (e != s_reg.dprev[k]) begin
               s_next.dly[k] = (s_reg.dead[k] != 8'h00);
               s_next.dcnt[k] = s_reg.dead[k] - 8'h01;
            end else if (s_reg.dly[k]) begin
               if (s_reg.dcnt[k] == 8'h00) begin
                  s_next.dly[k] = 1'b0;
               end else begin
                  s_next.dcnt[k] = s_reg.dcnt[k] - 8'h01;
               end
            end
            if (s_reg.dly[k] || e != s_reg.dprev[k]) begin
               e = 1'b0;
               o = 1'b0;
            end
         end else begin
            s_next.dly[k] = 1'b0;
            if (s_reg.ctl.mode == MODE_SYNC) begin
               o = e;
            end
         end
         ch[2*k] = e;
         ch[2*k+1] = o;
      end

      // -------------------------------------------------------------
      // Force low and brakes
      // -------------------------------------------------------------
      if (s_reg.ctl.force_en && force_low_evt) begin
         s_next.force_lo = 1'b1;
      end
      if (s_reg.force_lo) begin
         ch = '0;
      end
      src = fault;
      hit0 = |(src & s_reg.brk.en0);
      hit1 = |(src & s_reg.brk.en1);
      s_next.latching_brake_detector = hit0 |
         (s_reg.latching_brake_detector & ~rel);
      if (hit1) begin
         s_next.resuming_brake_detector = 1'b1;
         s_next.rcnt = RESUME_CNT;
      end else if (s_reg.resuming_brake_detector) begin
         if (s_reg.rcnt == 12'h000) begin
            s_next.resuming_brake_detector = 1'b0;
         end else begin
            s_next.rcnt = s_reg.rcnt - 12'h001;
         end
      end
      set_f.brk = {hit1, hit0};
      s_next.pin = ch ^ s_reg.ctl.pol;
      if (s_reg.latching_brake_detector ||
          s_reg.resuming_brake_detector) begin
         s_next.pin = s_reg.brk.level;
      end

      // -------------------------------------------------------------
      // Flags, interrupt and converter trigger
      // -------------------------------------------------------------
      s_next.flags = mpg_flags_t'((s_reg.flags & ~clr_f) | set_f);
      s_next.irq = |(s_reg.flags & s_reg.inten);
      s_next.adc =
         (s_reg.ctl.adc_sel[ADC_DN] && |set_f.down_compare_flag) ||
         (s_reg.ctl.adc_sel[ADC_CEN] && set_f.center_point_flag) ||
         (s_reg.ctl.adc_sel[ADC_UP] && |set_f.up_compare_flag) ||
         (s_reg.ctl.adc_sel[ADC_PER] && set_f.period_match_flag);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

endmodule : mpg_top

// ### mpg_top_asserts.sv
/*
 * Port-level checker for the motor PWM block.
 * Assumes the mpg_pkg register map; bound into every mpg_top.
 */
`timescale 1ns/1ps
module mpg_chk
   import mpg_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire mpg_bus_t bus,
   input wire logic [31:0] rdata,
   input wire logic module_clock_gate,
   input wire mpg_fault_t fault,
   input wire logic force_low_evt,
   input wire logic [5:0] channel_generator_output,
   input wire logic irq,
   input wire logic adc_trig
);
   // ------------------------------------------------------------
   // Shadow of control and brake setup
   // ------------------------------------------------------------
   logic [15:0] ctl_reg;
   logic [13:0] brk_reg;
   logic [2:0] quiet_reg;
   logic cfg_ok;
   logic [5:0] pins;
   assign pins = channel_generator_output;
   assign cfg_ok = quiet_reg > 3'h3 && brk_reg[7:0] == 8'h00
      && ctl_reg[15:10] == 6'h00;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctl_reg <= '0;
         brk_reg <= '0;
         quiet_reg <= '0;
      end else begin
         if (bus.wr && bus.addr == OFS_CTL) ctl_reg <= bus.wdata[15:0];
         if (bus.wr && bus.addr == OFS_BRK) brk_reg <= bus.wdata[13:0];
         if (bus.wr && (bus.addr == OFS_CTL || bus.addr == OFS_BRK))
            quiet_reg <= '0;
         else if (quiet_reg != 3'h7)
            quiet_reg <= quiet_reg + 3'h1;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
      else $error("read data outside read slot");
   a_unmapped_zero: assert property (bus.rd && bus.addr == 8'h3C
      |=> rdata == 32'h0) else $error("unmapped read not zero");
   a_reset_clear: assert property ($rose(rst_n)
      |-> pins == 6'h00 && !irq && !adc_trig) else $error("reset state");
   a_irq_masked: assert property (bus.wr && bus.addr == OFS_INTEN
      && bus.wdata[15:0] == 16'h0 |-> ##2 !irq) else $error("irq masked");
   a_gate_idle: assert property (!module_clock_gate [*4]
      |-> !adc_trig) else $error("trigger while gated");
   a_brake_pins: assert property (brk_reg[3] && quiet_reg > 3'h3
      && fault.fault_pin [*3] |=> pins == brk_reg[13:8])
      else $error("brake level not shown");
   a_force_low: assert property (ctl_reg[5] && cfg_ok
      && force_low_evt [*4] |-> pins == 6'h00) else $error("force low");
   a_sync_pair: assert property (cfg_ok && ctl_reg[1:0] == MODE_SYNC
      |-> pins[1] == pins[0] && pins[3] == pins[2] && pins[5] == pins[4])
      else $error("sync pair out of phase");
   a_compl_gap: assert property (cfg_ok && ctl_reg[1:0] == MODE_COMPL
      |-> (pins & (pins >> 1) & 6'h15) == 6'h00)
      else $error("pair both on");
endmodule : mpg_chk

bind mpg_top mpg_chk chk (.core_clk(core_clk), .rst_n(rst_n), .bus(bus),
   .rdata(rdata), .module_clock_gate(module_clock_gate), .fault(fault),
   .force_low_evt(force_low_evt),
   .channel_generator_output(channel_generator_output), .irq(irq),
   .adc_trig(adc_trig));

// ### mpg_stage.sv
/*
 * Power stage model: counts on-cycles of each gate drive, flags overlap.
 * Assumes the pins are already routed to the PWM function.
 */
`timescale 1ns/1ps
module mpg_stage (
   input wire logic core_clk,
   input wire logic clr,
   input wire logic [5:0] drive,
   output logic [15:0] hi [6],
   output logic shoot
);
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 6; i++) begin
         hi[i] <= clr ? 16'h0 : hi[i] + 16'(drive[i]);
      end
      shoot <= clr ? 1'b0 : shoot | ((drive & (drive >> 1) & 6'h15) != 0);
   end
endmodule : mpg_stage

// ### mpg_tb.sv
/*
 * Self-checking bench for the motor PWM block.
 * Assumes the checker binds itself and the stage model counts pins.
 */
`timescale 1ns/1ps
module mpg_tb_top;
   import mpg_pkg::*;
   logic core_clk = 0, rst_n = 0, gate = 1, frc = 0, clr = 1;
   mpg_bus_t bus = '0;
   mpg_fault_t fault = '0;
   logic [31:0] rdata, v, rdata_hold;
   logic [5:0] pins;
   logic irq, adc_trig, shoot;
   logic [15:0] hi [6];
   int n_mismatch = 0, checks_done = 0, trig_n = 0;
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) trig_n <= clr ? 0 : trig_n + int'(adc_trig);
   mpg_top dut (.core_clk(core_clk), .rst_n(rst_n), .bus(bus),
      .rdata(rdata), .module_clock_gate(gate), .fault(fault),
      .force_low_evt(frc), .channel_generator_output(pins), .irq(irq),
      .adc_trig(adc_trig));
   mpg_stage stage (.core_clk(core_clk), .clr(clr), .drive(pins),
      .hi(hi), .shoot(shoot));
   // ------------------------------------------------------------
   // Bus and compare helpers
   // ------------------------------------------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk) bus.wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge core_clk) bus.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task win(input int w);
      @(posedge core_clk) clr <= 1'b1;
      @(posedge core_clk) clr <= 1'b0;
      repeat (w) @(posedge core_clk);
      #1;
   endtask : win
   task setup(input logic [31:0] ctl);
      wr(OFS_CTL, 32'h0);
      wr(OFS_PSEL, 32'h0);
      wr(OFS_PERIOD, 32'h9);
      for (int n = 0; n < 6; n++) wr(8'(OFS_CMP0 + 4 * n), n == 1 ? 20 : 3);
      wr(8'h14, 32'h0);
      wr(OFS_CTL, ctl);
      repeat (30) @(posedge core_clk);
   endtask : setup
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_edge;
      setup(32'h14);
      for (int p = 0; p < 9; p++) begin
         wr(OFS_PSEL, p);
         repeat (10 << p) @(posedge core_clk);
         win(20 << p);
         chk("edge duty", 6 << p, hi[0]);
         chk("cmp above period", 20 << p, hi[1]);
         chk("cmp zero", 0, hi[2]);
      end
   endtask : t_edge
   task t_center;
      setup(32'h1C);
      wr(8'h14, 32'h0);
      repeat (20) @(posedge core_clk);
      win(40);
      chk("center duty", 12, hi[0]);
      chk("center high", 40, hi[1]);
      chk("center zero", 0, hi[2]);
      wr(OFS_INTEN, 32'h0);
      wr(OFS_FLAGS, 32'hFFFF);
      repeat (45) @(posedge core_clk);
      rd(OFS_FLAGS, v);
      chk("flags", 32'h0107, v & 32'h030F);
      chk("irq masked", 0, irq);
      wr(OFS_INTEN, 32'h1);
      repeat (2) @(posedge core_clk);
      #1 chk("irq on", 1, irq);
      wr(OFS_CTL, 32'h0);
      wr(OFS_FLAGS, 32'hFFFF);
      rd(OFS_FLAGS, v);
      chk("flags cleared", 0, v);
      for (int s = 0; s < 4; s++) begin
         setup(32'h1C | (32'h40 << s));
         win(40);
         // Up match also fires for the zero compare at count start
         chk("converter trigger", s == 2 ? 4 : 2, trig_n);
      end
   endtask : t_center
   task t_oneshot;
      setup(32'h0);
      win(1);
      wr(OFS_CTL, 32'h10);
      repeat (40) @(posedge core_clk);
      #1 chk("single pulse", 3, hi[0]);
      chk("single period", 10, hi[1]);
      rd(OFS_STATUS, v);
      chk("stopped", 0, v[17]);
   endtask : t_oneshot
   task t_pairs;
      setup(32'h16);
      wr(OFS_DEAD, 32'h010101);
      win(20);
      chk("sync odd", 6, hi[1]);
      chk("sync odd 2", 6, hi[5]);
      wr(OFS_CTL, 32'h15);
      win(20);
      chk("compl even", 2, hi[0]);
      chk("compl odd", 10, hi[1]);
      chk("overlap", 0, shoot);
      wr(OFS_CTL, 32'h0414);
      win(20);
      chk("inverted", 14, hi[0]);
   endtask : t_pairs
   task t_faults;
      setup(32'h34);
      wr(OFS_PSEL, 32'h3);
      repeat (100) @(posedge core_clk);
      frc <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1 chk("forced", 0, pins[1]);
      @(posedge core_clk) frc <= 1'b0;
      repeat (200) @(posedge core_clk);
      #1 chk("force ends", 1, pins[1]);
      wr(OFS_BRK, 32'h2A08);
      @(posedge core_clk) fault.fault_pin <= 1'b1;
      repeat (5) @(posedge core_clk);
      fault.fault_pin <= 1'b0;
      repeat (5) @(posedge core_clk);
      #1 chk("brake latched", 6'h2A, pins);
      rd(OFS_FLAGS, v);
      chk("brake flag", 1, v[14]);
      wr(OFS_BRKREL, 32'h1);
      wr(OFS_BRK, 32'h0);
      @(posedge core_clk) gate <= 1'b0;
      rd(OFS_STATUS, v);
      repeat (20) @(posedge core_clk);
      rd(OFS_STATUS, rdata_hold);
      chk("gated count", v[15:0], rdata_hold[15:0]);
      @(posedge core_clk) gate <= 1'b1;
      wr(OFS_CTL, 32'h0);
      wr(OFS_PERIOD, 32'h1234);
      rd(OFS_PERIOD, v);
      chk("period buffer", 32'h1234, v);
      rd(8'h3C, v);
      chk("unmapped", 0, v);
   endtask : t_faults
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   initial begin
      repeat (60000) @(posedge core_clk);
      n_mismatch++;
      stop_test;
   end
   initial begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      clr <= 1'b0;
      t_edge;
      t_center;
      t_oneshot;
      t_pairs;
      t_faults;
      stop_test;
   end
endmodule : mpg_tb_top
